// ### hw/spd_params.svh
// Constants for the STS-1 pointer reader and DS3 de-mapper.
// Assumes one STS-1 byte per accepted transfer, MSB first on the line.
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// Framing
`define SPD_A1          8'hf6
`define SPD_A2          8'h28
`define SPD_COLS        7'd90
`define SPD_ROWS        4'd9
`define SPD_TOH_COLS    7'd3
`define SPD_PTR_ROW     4'd3
`define SPD_LOSS_MISSES 3'd4

// Pointer word
`define SPD_PTR_MAX     10'd782
`define SPD_EC_ROW      10'd87
`define SPD_EC_FIRST    10'd522
`define SPD_I_MASK      10'h2aa
`define SPD_D_MASK      10'h155

// SPE row layout, payload byte indices exclude POH and fixed stuff columns
`define SPD_SPE_COLS    7'd87
`define SPD_FS_COL1     7'd29
`define SPD_FS_COL2     7'd58
`define SPD_CBYTE       7'd2
`define SPD_DATA_FIRST  7'd3
`define SPD_DATA_LAST   7'd79
`define SPD_DATA_TAIL   7'd80
`define SPD_BASE_BITS   13'd5589
`define SPD_S_NOMINAL   4'd3
`define SPD_S_NEG       4'd4
`define SPD_S_POS       4'd2

`endif

// ### hw/spd_pkg.sv
// Types for the STS-1 pointer reader and DS3 de-mapper.
// Assumes spd_params.svh for the numeric constants.
package spd_pkg;

    typedef enum logic [1:0] {SPD_HUNT, SPD_PRESYNC, SPD_SYNC} spd_fstate_t;

    typedef enum logic [1:0] {SPD_JUST_NOMINAL, SPD_JUST_NEG, SPD_JUST_POS, SPD_JUST_OTHER} spd_just_t;

    typedef struct packed {
        logic        in_frame;
        logic        ptr_valid;
        logic [9:0]  ptr_value;
        logic        ptr_bad;
        logic        ptr_inc;
        logic        ptr_miss;
        logic        spe_done;
        logic [12:0] spe_bits;
        spd_just_t   spe_just;
    } spd_status_t;

    typedef struct packed {
        spd_fstate_t fstate;
        logic [2:0]  misses;
        logic [7:0]  prev;
        logic [3:0]  row;
        logic [6:0]  col;
        logic [9:0]  ec_off;
        logic [7:0]  h1;
        logic [9:0]  act_ptr;
        logic        ptr_ok;
        logic        inc_pend;
        logic        skip;
        logic        spe_on;
        logic [3:0]  spe_row;
        logic [6:0]  spe_col;
        logic [6:0]  sbyte;
        logic [3:0]  s_cnt;
        logic [15:0] acc;
        logic [3:0]  acnt;
        logic        ptr_bad;
        logic        ptr_inc;
        logic        ptr_miss;
        logic        spe_done;
        logic [12:0] spe_bits;
        spd_just_t   spe_just;
    } spd_state_t;

endpackage : spd_pkg

// ### hw/spd_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
module spd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } spd_fifo_state_t;

    spd_fifo_state_t st;
    spd_fifo_state_t next_st;
    logic            wr_en;
    logic            rd_en;

    assign in_ready  = st.cnt != (AW+1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data  = st.mem[st.rd];
    assign wr_en     = in_valid && in_ready;
    assign rd_en     = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = st.wr + 1'b1;
        end
        if (rd_en) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : spd_fifo

// ### hw/spd_rx.sv
// STS-1 receiver: frame alignment, H1/H2 pointer reading, SPE location
// and DS3 de-mapping through the stuff indicator bits.
// Assumes the STS-1 byte stream comes from logic on the same clock.
// Summary of operation
// - Nominal SPE carries 5592 bits, three S data
// - Negative justification: 5593 bits, four S data
// - Positive justification: 5591 bits, two S data
// - Locate SPE only while frame aligned
// - Pointer is low ten bits, H1 high
// - Pointer zero means byte after H3
// - Pointer above 782 is invalid, ignored
// - Offsets count rows from H3; row0 starts 522
// - SPE may span two frames
// - One stuff opportunity bit per SPE row
// - Five indicator bits: zeros data, ones stuff
// - After increment, expect pointer plus one
`include "spd_params.svh"
module spd_rx (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            srst,
    // STS-1 byte stream
    input  wire logic            sts_valid,
    output logic                 sts_ready,
    input  wire logic [7:0]      sts_data,
    // De-mapped DS3 bytes, MSB first
    output logic                 ds3_valid,
    input  wire logic            ds3_ready,
    output logic [7:0]           ds3_data,
    // Status
    output spd_pkg::spd_status_t status
);
    import spd_pkg::*;

    spd_state_t  st;
    spd_state_t  next_st;
    logic        adv;
    logic        fifo_ready;
    logic        push;
    logic [7:0]  push_data;
    logic [9:0]  ptr_raw;
    logic [9:0]  cur_off;
    logic        ptr_ev;
    logic        inv_i;
    logic        inv_d;
    logic        j1;
    logic        s_stuff;
    logic [6:0]  scol;
    logic [3:0]  srow;
    logic [3:0]  nbits;
    logic [7:0]  nval;
    logic [15:0] acc_sum;
    logic [3:0]  cnt_sum;

    assign adv       = sts_valid && fifo_ready;
    assign sts_ready = fifo_ready;
    assign ptr_raw   = {st.h1[1:0], sts_data};
    assign ptr_ev    = adv && st.fstate == SPD_SYNC && st.row == `SPD_PTR_ROW && st.col == 7'd1;
    assign inv_i     = $countones((ptr_raw ^ st.act_ptr) & `SPD_I_MASK) >= 3;
    assign inv_d     = $countones((ptr_raw ^ st.act_ptr) & `SPD_D_MASK) >= 3;
    // Majority keeps a single bit error from flipping the decision
    assign s_stuff   = $countones(sts_data[7:3]) >= 3;

    always_comb begin
        next_st          = st;
        next_st.ptr_bad  = 1'b0;
        next_st.ptr_inc  = 1'b0;
        next_st.ptr_miss = 1'b0;
        next_st.spe_done = 1'b0;
        nbits            = 4'd0;
        nval             = 8'h00;
        j1               = 1'b0;
        scol             = st.spe_col;
        srow             = st.spe_row;
        // Offset 0 sits right after H3, later rows follow on
        cur_off = (st.row == `SPD_PTR_ROW && st.col == `SPD_TOH_COLS) ? 10'd0 : st.ec_off;
        if (adv) begin
            next_st.prev = sts_data;
            if (st.col == `SPD_COLS - 7'd1) begin
                next_st.col = 7'd0;
                next_st.row = (st.row == `SPD_ROWS - 4'd1) ? 4'd0 : st.row + 4'd1;
            end else begin
                next_st.col = st.col + 7'd1;
            end
            case (st.fstate)
                SPD_HUNT: begin
                    if (st.prev == `SPD_A1 && sts_data == `SPD_A2) begin
                        next_st.fstate = SPD_PRESYNC;
                        next_st.row    = 4'd0;
                        next_st.col    = 7'd2;
                    end
                end
                SPD_PRESYNC, SPD_SYNC: begin
                    if (st.row == 4'd0 && st.col == 7'd1) begin
                        if (st.prev == `SPD_A1 && sts_data == `SPD_A2) begin
                            next_st.misses = 3'd0;
                            next_st.fstate = SPD_SYNC;
                        end else if (st.fstate == SPD_PRESYNC || st.misses == `SPD_LOSS_MISSES - 3'd1) begin
                            next_st.misses = 3'd0;
                            next_st.fstate = SPD_HUNT;
                        end else begin
                            next_st.misses = st.misses + 3'd1;
                        end
                    end
                end
                default: begin
                    next_st.fstate = SPD_HUNT;
                end
            endcase
            // Counted from PRESYNC on, so the first aligned frame reads 522 in row 0
            if (st.fstate != SPD_HUNT && st.col >= `SPD_TOH_COLS) begin
                next_st.ec_off = (cur_off == `SPD_PTR_MAX) ? 10'd0 : cur_off + 10'd1;
            end
            if (st.fstate == SPD_SYNC) begin
                if (st.row == `SPD_PTR_ROW && st.col == 7'd0) begin
                    next_st.h1 = sts_data;
                end
                if (ptr_ev) begin
                    if (ptr_raw > `SPD_PTR_MAX) begin
                        next_st.ptr_bad = 1'b1;
                    end else if (st.ptr_ok && inv_i) begin
                        // Stuff byte follows H3 in this frame
                        next_st.act_ptr  = (st.act_ptr == `SPD_PTR_MAX) ? 10'd0 : st.act_ptr + 10'd1;
                        next_st.skip     = 1'b1;
                        next_st.inc_pend = 1'b1;
                        next_st.ptr_inc  = 1'b1;
                    end else if (!(st.ptr_ok && inv_d)) begin
                        next_st.ptr_miss = st.inc_pend && ptr_raw != st.act_ptr;
                        next_st.inc_pend = 1'b0;
                        next_st.act_ptr  = ptr_raw;
                        next_st.ptr_ok   = 1'b1;
                    end
                end
                if (st.col >= `SPD_TOH_COLS) begin
                    if (st.skip && cur_off == 10'd0) begin
                        next_st.skip = 1'b0;
                    end else begin
                        // Counters carry across the frame boundary
                        j1 = st.ptr_ok && cur_off == st.act_ptr;
                        if (j1) begin
                            scol          = 7'd0;
                            srow          = 4'd0;
                            next_st.s_cnt = 4'd0;
                        end
                        if (j1 || st.spe_on) begin
                            next_st.spe_on = 1'b1;
                            if (scol == 7'd0) begin
                                next_st.sbyte = 7'd0;
                            end else if (scol != `SPD_FS_COL1 && scol != `SPD_FS_COL2) begin
                                next_st.sbyte = st.sbyte + 7'd1;
                                if (st.sbyte == `SPD_CBYTE) begin
                                    if (!s_stuff) begin
                                        nbits         = 4'd1;
                                        nval          = {7'h00, sts_data[0]};
                                        next_st.s_cnt = next_st.s_cnt + 4'd1;
                                    end
                                end else if (st.sbyte >= `SPD_DATA_FIRST && st.sbyte <= `SPD_DATA_LAST) begin
                                    nbits = 4'd8;
                                    nval  = sts_data;
                                end else if (st.sbyte == `SPD_DATA_TAIL) begin
                                    nbits = 4'd5;
                                    nval  = {3'h0, sts_data[7:3]};
                                end
                            end
                            if (scol == `SPD_SPE_COLS - 7'd1) begin
                                next_st.spe_col = 7'd0;
                                if (srow == `SPD_ROWS - 4'd1) begin
                                    next_st.spe_on   = 1'b0;
                                    next_st.spe_done = 1'b1;
                                    next_st.spe_bits = `SPD_BASE_BITS + 13'(next_st.s_cnt);
                                    case (next_st.s_cnt)
                                        `SPD_S_NOMINAL: next_st.spe_just = SPD_JUST_NOMINAL;
                                        `SPD_S_NEG:     next_st.spe_just = SPD_JUST_NEG;
                                        `SPD_S_POS:     next_st.spe_just = SPD_JUST_POS;
                                        default:        next_st.spe_just = SPD_JUST_OTHER;
                                    endcase
                                end else begin
                                    next_st.spe_row = srow + 4'd1;
                                end
                            end else begin
                                next_st.spe_col = scol + 7'd1;
                                next_st.spe_row = srow;
                            end
                        end
                    end
                end
            end
            if (next_st.fstate != SPD_SYNC) begin
                next_st.spe_on = 1'b0;
            end
        end
        // Bit packer; at most one byte leaves per accepted line byte
        acc_sum   = (st.acc << nbits) | {8'h00, nval};
        cnt_sum   = st.acnt + nbits;
        push      = cnt_sum >= 4'd8;
        push_data = 8'h00;
        if (push) begin
            push_data = 8'(acc_sum >> (cnt_sum - 4'd8));
            cnt_sum   = cnt_sum - 4'd8;
        end
        next_st.acc  = acc_sum;
        next_st.acnt = cnt_sum;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // A full buffer stalls the line side through sts_ready
    spd_fifo #(
        .WIDTH (8),
        .DEPTH (4)
    ) u_fifo (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (ds3_valid),
        .out_ready (ds3_ready),
        .out_data  (ds3_data)
    );

    assign status = '{in_frame:  st.fstate == SPD_SYNC,
                      ptr_valid: st.ptr_ok,
                      ptr_value: st.act_ptr,
                      ptr_bad:   st.ptr_bad,
                      ptr_inc:   st.ptr_inc,
                      ptr_miss:  st.ptr_miss,
                      spe_done:  st.spe_done,
                      spe_bits:  st.spe_bits,
                      spe_just:  st.spe_just};

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_BITS_NOMINAL: assert property (st.spe_done && st.spe_just == SPD_JUST_NOMINAL
        |-> st.spe_bits == 13'd5592)
        else $error("nominal SPE bit count wrong");
    AST_BITS_NEG: assert property (st.spe_done && st.spe_just == SPD_JUST_NEG |-> st.spe_bits == 13'd5593)
        else $error("negative stuff SPE bit count wrong");
    AST_BITS_POS: assert property (st.spe_done && st.spe_just == SPD_JUST_POS |-> st.spe_bits == 13'd5591)
        else $error("positive stuff SPE bit count wrong");
    AST_NO_SPE_UNALIGNED: assert property (st.fstate != SPD_SYNC |-> !st.spe_on && !st.spe_done)
        else $error("SPE tracked without frame alignment");
    AST_PTR_TAKEN: assert property (ptr_ev && ptr_raw <= 10'd782 && !(st.ptr_ok && (inv_i || inv_d))
        |=> st.ptr_ok && st.act_ptr == $past(ptr_raw))
        else $error("pointer word not taken from H1/H2");
    AST_J1_AFTER_H3: assert property (adv && st.fstate == SPD_SYNC && next_st.fstate == SPD_SYNC && st.ptr_ok
        && st.act_ptr == 10'd0 && !st.skip && st.row == 4'd3 && st.col == 7'd3
        |=> st.spe_on && st.spe_col == 7'd1)
        else $error("zero pointer did not start SPE after H3");
    AST_PTR_INVALID: assert property (ptr_ev && ptr_raw > 10'd782
        |=> st.ptr_bad && st.act_ptr == $past(st.act_ptr))
        else $error("invalid pointer was used");
    AST_ROW0_OFFSET: assert property (adv && st.fstate == SPD_SYNC && st.row == 4'd0 && st.col == 7'd3
        |-> cur_off == 10'd522)
        else $error("first frame row offset not 522");
    AST_S_STUFF: assert property (adv && st.spe_on && st.sbyte == 7'd2 && !j1 && sts_data[7:3] == 5'h1f
        && scol != 7'd0 && scol != 7'd29 && scol != 7'd58 |=> st.s_cnt == $past(st.s_cnt))
        else $error("stuff bit counted as data");
    AST_INC_NEXT: assert property (st.ptr_inc && st.act_ptr != 10'd0
        |-> st.inc_pend && st.act_ptr == $past(st.act_ptr) + 10'd1)
        else $error("increment not followed by pointer plus one");

endmodule : spd_rx

// ### verif/spd_sts_src.sv
// STS-1 source model: continuous 90x9 frames carrying one DS3 mapping.
// Assumes bytes are taken on sts_valid && sts_ready; controls are latched
// at frame end or SPE start, so a held byte never changes under the design.
module spd_sts_src (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // Controls from the bench
    input  wire logic [9:0] ptr,
    input  wire logic [3:0] s_rows,
    input  wire logic       vote,
    input  wire logic       inc_req,
    input  wire logic       bad_ptr,
    input  wire logic       break_a1,
    // Byte stream
    output logic            sts_valid = 1'b0,
    input  wire logic       sts_ready,
    output logic [7:0]      sts_data,
    output logic            frame_tick = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int         row = 0, col = 0, p = 0, s_cur = 3, ec, idx, sr, sc, pi;
    logic       inc_f = 1'b0, bad_f = 1'b0, brk_f = 1'b0, v_cur = 1'b0;
    logic       take;
    logic [9:0] pw;
    logic [4:0] cb;
    assign take = sts_valid && sts_ready;
    always_comb begin
        ec  = (row >= 3) ? (row - 3) * 87 + col - 3 : 522 + row * 87 + col - 3;
        idx = (ec >= p) ? ec - p : ec + 783 - p;
        sr  = idx / 87;
        sc  = idx % 87;
        pi  = sc - 1 - (sc > 29) - (sc > 58);
        pw  = bad_f ? 10'h3ff : (inc_f ? 10'(p) ^ 10'h2aa : 10'(p));
        // Vote mode sends two wrong indicator bits per row
        cb  = (sr >= s_cur) ? (v_cur ? 5'h1c : 5'h1f) : (v_cur ? 5'h03 : 5'h00);
        if (col < 3) begin
            case (row * 4 + col)
                0:       sts_data = brk_f ? 8'h00 : 8'hf6;
                1:       sts_data = 8'h28;
                12:      sts_data = {6'h18, pw[9:8]};
                13:      sts_data = pw[7:0];
                default: sts_data = 8'h00;
            endcase
        end else if (inc_f && ec == 0) begin
            sts_data = 8'h00;
        end else if (sc == 0 || sc == 29 || sc == 58) begin
            sts_data = 8'h00;
        end else if (pi == 2) begin
            sts_data = {cb, 3'h1};
        end else begin
            sts_data = (pi >= 3 && pi <= 80) ? 8'h5a : 8'h00;
        end
    end
    always @(posedge clock) begin
        frame_tick <= take && row == 8 && col == 80;
        if (srst) begin
            sts_valid <= 1'b0;
            row       <= 0;
            col       <= 0;
            p         <= ptr;
            inc_f     <= 1'b0;
            bad_f     <= 1'b0;
            brk_f     <= 1'b0;
            s_cur     <= s_rows;
            v_cur     <= vote;
        end else begin
            sts_valid <= 1'b1;
            if (take) begin
                col <= (col == 89) ? 0 : col + 1;
                if (col == 89) begin
                    row <= (row == 8) ? 0 : row + 1;
                end
                if (row == 8 && col == 89) begin
                    p     <= ptr;
                    inc_f <= inc_req;
                    bad_f <= bad_ptr;
                    brk_f <= break_a1;
                end
                if (inc_f && ec == 0) begin
                    p <= p + 1;
                end else if (col >= 3 && idx == 0) begin
                    s_cur <= s_rows;
                    v_cur <= vote;
                end
            end
        end
    end
endmodule : spd_sts_src

// ### verif/test_spd_rx.sv
// Self-checking bench for spd_rx fed by the STS-1 source model.
// Assumes one 125 MHz clock; bench inputs move on falling edges.
module test_spd_rx;
    timeunit 1ns;
    timeprecision 1ps;
    import spd_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        ds3_ready = 1'b1;
    logic [9:0]  ptr = 10'd700;
    logic [3:0]  s_rows = 4'h3;
    logic        vote = 1'b0;
    logic        inc_req = 1'b0;
    logic        bad_ptr = 1'b0;
    logic        break_a1 = 1'b0;
    logic        sts_valid, sts_ready, ds3_valid, frame_tick;
    logic [7:0]  sts_data, ds3_data;
    spd_status_t status;
    int          mismatches = 0, checks = 0, cyc = 0, pops = 0, ones = 0;
    always #4 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    // Popped DS3 bytes and their one bits, taken with the design's own handshake
    always @(posedge clock) begin
        if (ds3_valid && ds3_ready) begin
            pops <= pops + 1;
            ones <= ones + $countones(ds3_data);
        end
    end
    spd_rx DUT (.clock(clock), .srst(srst), .sts_valid(sts_valid), .sts_ready(sts_ready),
        .sts_data(sts_data), .ds3_valid(ds3_valid), .ds3_ready(ds3_ready), .ds3_data(ds3_data),
        .status(status));
    spd_sts_src SRC (.clock(clock), .srst(srst), .ptr(ptr), .s_rows(s_rows), .vote(vote),
        .inc_req(inc_req), .bad_ptr(bad_ptr), .break_a1(break_a1), .sts_valid(sts_valid),
        .sts_ready(sts_ready), .sts_data(sts_data), .frame_tick(frame_tick));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %0t %s: saw %h want %h", $time, what, seen, want);
        end
    endtask : check
    // Bounded wait on one condition, sampled where outputs are settled
    task automatic wait_flag(input int sel, input int lim, input bit must, output bit hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge clock);
            case (sel)
                0:       hit = (status.spe_done === 1'b1);
                1:       hit = (status.ptr_bad === 1'b1);
                2:       hit = (status.ptr_inc === 1'b1);
                3:       hit = (status.ptr_miss === 1'b1);
                4:       hit = (sts_ready === 1'b0);
                5:       hit = (ds3_valid === 1'b0);
                default: hit = (frame_tick === 1'b1);
            endcase
        end
        if (must && !hit) begin
            mismatches++;
            $display("BAD %0t wait %0d ran out", $time, sel);
            summarize();
        end
    endtask : wait_flag
    task automatic wait_frames(input int n);
        bit hit;
        repeat (n) wait_flag(6, 2000, 1'b1, hit);
    endtask : wait_frames
    task automatic restart(input logic [9:0] p);
        @(negedge clock);
        srst = 1'b1;
        ptr = p;
        s_rows = 4'h3;
        vote = 1'b0;
        repeat (12) @(negedge clock);
        srst = 1'b0;
    endtask : restart
    task automatic spe_case(input logic [3:0] s, input logic v, input logic [12:0] bits,
                            input spd_just_t j, input bit timed);
        int t0;
        int p0;
        int n0;
        bit hit;
        s_rows = s;
        vote = v;
        wait_flag(0, 1700, 1'b1, hit);
        t0 = cyc;
        p0 = pops;
        n0 = ones;
        wait_flag(0, 1700, 1'b1, hit);
        if (timed) begin
            check(16'(cyc - t0), 16'd810, "spe period");
            // Source payload is 5a bytes and S bits of 1: 9 rows of 311 ones plus 3
            if (bits == 13'd5592) begin
                check(16'(pops - p0), 16'd699, "ds3 bytes");
                check(16'(ones - n0), 16'd2802, "ds3 ones");
            end
        end
        check({3'h0, status.spe_bits}, {3'h0, bits}, "spe bits");
        check({14'h0, status.spe_just}, {14'h0, j}, "spe just");
    endtask : spe_case
    task automatic t_align();
        restart(10'd700);
        wait_frames(1);
        check({15'h0, status.in_frame}, 16'h0, "early frame");
        check({15'h0, status.ptr_valid}, 16'h0, "early ptr");
        wait_frames(1);
        check({15'h0, status.in_frame}, 16'h1, "in frame");
        check({15'h0, status.ptr_valid}, 16'h1, "ptr valid");
        check({6'h0, status.ptr_value}, 16'd700, "ptr value");
    endtask : t_align
    task automatic t_ptr(input logic [9:0] p);
        restart(p);
        wait_frames(2);
        check({6'h0, status.ptr_value}, {6'h0, p}, "ptr value");
        spe_case(4'd3, 1'b0, 13'd5592, SPD_JUST_NOMINAL, 1'b1);
    endtask : t_ptr
    task automatic t_bad();
        bit hit;
        bad_ptr = 1'b1;
        wait_flag(1, 1700, 1'b1, hit);
        bad_ptr = 1'b0;
        check({6'h0, status.ptr_value}, {6'h0, ptr}, "kept ptr");
        spe_case(4'd3, 1'b0, 13'd5592, SPD_JUST_NOMINAL, 1'b1);
    endtask : t_bad
    task automatic t_inc();
        bit hit;
        inc_req = 1'b1;
        wait_flag(2, 1700, 1'b1, hit);
        inc_req = 1'b0;
        ptr = ptr + 10'd1;
        wait_flag(3, 1700, 1'b0, hit);
        check({15'h0, hit}, 16'h0, "false miss");
        check({6'h0, status.ptr_value}, {6'h0, ptr}, "ptr plus one");
        spe_case(4'd3, 1'b0, 13'd5592, SPD_JUST_NOMINAL, 1'b1);
        // Second increment left unconfirmed by the next frame
        inc_req = 1'b1;
        wait_flag(2, 1700, 1'b1, hit);
        inc_req = 1'b0;
        wait_flag(3, 1700, 1'b1, hit);
    endtask : t_inc
    task automatic t_stall();
        bit hit;
        ds3_ready = 1'b0;
        wait_flag(4, 100, 1'b1, hit);
        repeat (30) @(negedge clock);
        check({15'h0, sts_ready}, 16'h0, "held full");
        check({15'h0, ds3_valid}, 16'h1, "stored");
        ds3_ready = 1'b1;
        wait_flag(5, 400, 1'b1, hit);
        spe_case(4'd3, 1'b0, 13'd5592, SPD_JUST_NOMINAL, 1'b0);
    endtask : t_stall
    task automatic t_loss();
        wait_frames(1);
        break_a1 = 1'b1;
        wait_frames(3);
        check({15'h0, status.in_frame}, 16'h1, "three misses");
        wait_frames(1);
        check({15'h0, status.in_frame}, 16'h0, "four misses");
        break_a1 = 1'b0;
    endtask : t_loss
    initial begin
        t_align();
        spe_case(4'd3, 1'b0, 13'd5592, SPD_JUST_NOMINAL, 1'b1);
        spe_case(4'd4, 1'b0, 13'd5593, SPD_JUST_NEG, 1'b1);
        spe_case(4'd2, 1'b0, 13'd5591, SPD_JUST_POS, 1'b1);
        spe_case(4'd2, 1'b1, 13'd5591, SPD_JUST_POS, 1'b1);
        spe_case(4'd0, 1'b0, 13'd5589, SPD_JUST_OTHER, 1'b1);
        t_stall();
        t_loss();
        t_ptr(10'd0);
        t_ptr(10'd782);
        t_ptr(10'd87);
        t_bad();
        t_inc();
        summarize();
    end
endmodule : test_spd_rx
